//--- common/diag_pkg.sv
// package: register map, field layout and timing constants of the diagnostic monitor
package diag_pkg;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] ENABLE_CONTROL_OFFSET       = 8'h00;
  localparam logic [7:0] ENABLE_CONTROL_TWO_OFFSET   = 8'h04;
  localparam logic [7:0] CALIB_MEMORY_STATUS_OFFSET  = 8'h08;
  localparam logic [7:0] RAM_SELFTEST_STATUS_OFFSET  = 8'h0C;
  localparam logic [7:0] OUTPUT_ONE_DATA_OFFSET      = 8'h10;
  localparam logic [7:0] OUTPUT_TWO_DATA_OFFSET      = 8'h14;
  localparam logic [7:0] RESET_CAUSE_OFFSET          = 8'h18;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int OSC_MON_EN_BIT    = 0;
  localparam int CORE_WD_EN_BIT    = 1;
  localparam int WD_SERVICE_BIT    = 2;
  localparam int SELFTEST_START_BIT = 0;
  localparam int CRC_ERR_BIT       = 0;
  localparam int TRIM_ERR_BIT      = 1;
  localparam int SELFTEST_DONE_BIT = 0;
  localparam int SELFTEST_FAIL_BIT = 1;
  localparam int CAUSE_WD_BIT      = 0;
  localparam int DAC_WIDTH         = 12;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [2:0] ENABLE_CONTROL_RESET = 3'h3;

  // ****************************************************************
  // calibration layout and crc
  // ****************************************************************
  localparam int BANK_BYTES         = 16;
  localparam int CRC_BANK           = 5;
  localparam int CRC_BYTE_INDEX     = 8;
  localparam logic [7:0] CRC_POLY   = 8'h07;
  localparam logic [7:0] CRC_INIT   = 8'hFF;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_HZ             = 100_000_000;
  localparam int WD_TIMEOUT_MS      = 500;
  localparam int WD_TIMEOUT_CYCLES  = (CLK_HZ / 1000) * WD_TIMEOUT_MS;
  localparam int OSC_MIN_MHZ        = 35;
  localparam int OSC_MAX_MHZ        = 45;
  localparam int OSC_GATE_US        = 10;
  localparam int OSC_GATE_CYCLES    = (CLK_HZ / 1_000_000) * OSC_GATE_US;
  localparam int OSC_MIN_COUNT      = OSC_MIN_MHZ * OSC_GATE_US;
  localparam int OSC_MAX_COUNT      = OSC_MAX_MHZ * OSC_GATE_US;

  // ****************************************************************
  // carriers and states
  // ****************************************************************
  typedef struct packed {
    logic       load;
    logic [2:0] bank;
    logic [3:0] index;
    logic [7:0] data;
  } cal_byte_type;

  typedef enum logic [1:0] {
    BIST_IDLE  = 2'b00,
    BIST_WRITE = 2'b01,
    BIST_READ  = 2'b10,
    BIST_DONE  = 2'b11
  } bist_state_type;

endpackage

//--- tb/main_osc_model.sv
// partner model: main oscillator, internal or external source
`timescale 1ns/10ps
module main_osc_model (
  input  wire logic [1:0] mode,
  output logic            osc_clk
);
  // ************
  // free running source, never stopped
  // ************
  realtime half;
  initial osc_clk = 1'b0;
  always begin
    case (mode)
      2'h0: half = 12.5; // internal 40 MHz
      2'h1: half = 12.2; // external crystal near 41 MHz
      2'h2: half = 16.7; // near 30 MHz, too slow
      default: half = 10.0; // 50 MHz, too fast
    endcase
    #(half) osc_clk = ~osc_clk;
  end
endmodule // main_osc_model

//--- tb/safety_monitor_properties.sv
// checker: port properties of the diagnostic safety monitor
`timescale 1ns/10ps
module safety_monitor_properties
  import diag_pkg::*;
#(
  parameter int WD_CYCLES = 200
) (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [7:0]           paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 core_reset_n,
  input wire logic                 device_reset_req,
  input wire logic [DAC_WIDTH-1:0] analog_output_one,
  input wire logic [DAC_WIDTH-1:0] analog_output_two
);
  // ************
  // helper state
  // ************
  logic        osc_en_r, osc_en_nxt, wd_en_r, wd_en_nxt, svc_r, svc_nxt;
  logic        core_q_r, wr_ctl, fire;
  int unsigned cnt_r, cnt_nxt;
  assign wr_ctl = psel && penable && pwrite && paddr == ENABLE_CONTROL_OFFSET;
  assign fire   = core_q_r && !core_reset_n;
  // slack of four cycles: the design sees a service one cycle late
  always_comb begin
    osc_en_nxt = wr_ctl ? pwdata[OSC_MON_EN_BIT] : osc_en_r;
    wd_en_nxt  = wr_ctl ? pwdata[CORE_WD_EN_BIT] : wd_en_r;
    svc_nxt    = wr_ctl ? pwdata[WD_SERVICE_BIT] : svc_r;
    cnt_nxt    = wd_en_r ? cnt_r + 1 : 0;
    if (fire || svc_nxt != svc_r) begin
      cnt_nxt = 0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_en_r <= ENABLE_CONTROL_RESET[OSC_MON_EN_BIT];
      wd_en_r  <= ENABLE_CONTROL_RESET[CORE_WD_EN_BIT];
      svc_r    <= 1'b0;
      core_q_r <= 1'b0;
      cnt_r    <= 0;
    end else begin
      osc_en_r <= osc_en_nxt;
      wd_en_r  <= wd_en_nxt;
      svc_r    <= svc_nxt;
      core_q_r <= core_reset_n;
      cnt_r    <= cnt_nxt;
    end
  end
  // ************
  // properties
  // ************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_CORE_RELEASE: assert property (
    $rose(presetn) |-> ##[1:3] core_reset_n)
    else $error("core reset not released after device reset");
  AST_WD_ONE_CYCLE: assert property (
    $fell(core_reset_n) |=> core_reset_n)
    else $error("watchdog core reset longer than one cycle");
  AST_WD_NOT_LATE: assert property (cnt_r <= WD_CYCLES + 4)
    else $error("watchdog did not fire in time");
  AST_WD_NOT_EARLY: assert property (fire |-> cnt_r + 4 >= WD_CYCLES)
    else $error("watchdog fired too early");
  AST_WD_OFF: assert property ((!wd_en_r)[*2] |-> core_reset_n)
    else $error("disabled watchdog reset the core");
  AST_WD_CLEARS: assert property ($fell(core_reset_n) |-> ##[0:1]
    (analog_output_one == '0 && analog_output_two == '0))
    else $error("outputs not cleared by watchdog reset");
  AST_OSC_OFF: assert property (
    (!osc_en_r)[*3] |-> !device_reset_req)
    else $error("disabled oscillator monitor requested reset");
  AST_OSC_PULSE: assert property (
    device_reset_req |=> (!device_reset_req)[*8])
    else $error("device reset request not a lone pulse");
  AST_SVC_HIDDEN: assert property (psel && penable && !pwrite &&
    paddr == ENABLE_CONTROL_OFFSET |-> !prdata[WD_SERVICE_BIT])
    else $error("service level visible on read");
  cover property ($fell(core_reset_n));
  cover property (device_reset_req);
  cover property (psel && penable && paddr == RAM_SELFTEST_STATUS_OFFSET &&
    prdata[SELFTEST_DONE_BIT]);
endmodule // safety_monitor_properties

bind diagnostic_safety_monitor safety_monitor_properties #(
  .WD_CYCLES(WD_CYCLES)
) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .core_reset_n(core_reset_n), .device_reset_req(device_reset_req),
  .analog_output_one(analog_output_one),
  .analog_output_two(analog_output_two)
);

//--- tb/tb.sv
// testbench: register, watchdog, crc, self-test and oscillator scenarios
`timescale 1ns/10ps
module tb
  import diag_pkg::*;
();
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic                 trim_valid, osc_clk, core_reset_n, device_reset_req;
  logic [7:0]           paddr;
  logic [31:0]          pwdata, prdata, q;
  logic [1:0]           osc_mode;
  logic [DAC_WIDTH-1:0] out_one, out_two;
  cal_byte_type         cal_byte;
  logic [31:0]          mdl [7];
  logic                 svcl;
  int                   miscompares, checks_done, fires, seed, f0, n, i, cnt;

  diagnostic_safety_monitor #(
    .WD_CYCLES(200), .RAM_DEPTH(16), .RAM_AW(4)
  ) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .main_osc_clk(osc_clk),
    .trim_valid(trim_valid), .cal_byte(cal_byte),
    .core_reset_n(core_reset_n), .device_reset_req(device_reset_req),
    .analog_output_one(out_one), .analog_output_two(out_two));
  main_osc_model u_osc (.mode(osc_mode), .osc_clk(osc_clk));

  always #5 pclk = ~pclk;
  always @(negedge core_reset_n) if (presetn === 1'b1) fires++;

  // ************
  // checking and bus tasks
  // ************
  task automatic report_and_stop();
    if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    chk_w({31'h0, got}, {31'h0, exp});
  endtask
  task automatic give_up();
    miscompares++;
    $display("wrong value at %0t: wait ran out", $time);
    report_and_stop();
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int k;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 16);
    r = prdata;
    chk_b(pslverr, a > RESET_CAUSE_OFFSET);
    psel <= 1'b0; penable <= 1'b0;
    if (pready !== 1'b1) give_up();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, q);
    case (a)
      ENABLE_CONTROL_OFFSET: mdl[0] = d & 32'h3;
      OUTPUT_ONE_DATA_OFFSET, OUTPUT_TWO_DATA_OFFSET:
        mdl[a[4:2]] = d & 32'hFFF;
      CALIB_MEMORY_STATUS_OFFSET, RESET_CAUSE_OFFSET: mdl[a[4:2]] &= d;
      default: ;
    endcase
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0, q);
    chk_w(q, a > RESET_CAUSE_OFFSET ? 32'h0 : mdl[a[4:2]]);
  endtask
  task automatic wr_en(input logic osc, input logic wd);
    wr(ENABLE_CONTROL_OFFSET, {29'h0, svcl, wd, osc});
  endtask
  task automatic rst(input logic t);
    @(posedge pclk);
    presetn <= 1'b0; trim_valid <= t;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    mdl = '{32'h3, 32'h0, {30'h0, !t, 1'b0}, 32'h0, 32'h0, 32'h0, 32'h0};
    svcl = 1'b0;
  endtask
  task automatic cal(input logic [2:0] b, input logic [3:0] x,
                     input logic [7:0] d);
    @(posedge pclk);
    cal_byte <= {1'b1, b, x, d};
    @(posedge pclk);
    cal_byte.load <= 1'b0;
  endtask
  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] d);
    c = c ^ d;
    for (int k = 0; k < 8; k++)
      c = {c[6:0], 1'b0} ^ (c[7] ? CRC_POLY : 8'h00);
    return c;
  endfunction
  // bank zero interleaved: it must not disturb the sum
  task automatic crc_run(input logic bad);
    int bl [6] = '{1, 2, 0, 3, 4, 5};
    logic [7:0] c, d;
    c = CRC_INIT;
    foreach (bl[b]) begin
      for (int k = 0; k < BANK_BYTES; k++) begin
        d = 8'($random(seed));
        if (bl[b] == CRC_BANK && k == CRC_BYTE_INDEX) continue;
        cal(3'(bl[b]), 4'(k), d);
        if (bl[b] != 0) c = crc8(c, d);
      end
    end
    cal(3'(CRC_BANK), 4'(CRC_BYTE_INDEX), bad ? ~c : c);
    mdl[2][CRC_ERR_BIT] = bad;
  endtask

  // ************
  // main sequence
  // ************
  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; trim_valid = 1'b0; cal_byte = '0;
    osc_mode = 2'h0; seed = 51095; fires = 0; miscompares = 0; checks_done = 0;
    rst(1'b0);
    rd(ENABLE_CONTROL_OFFSET);
    rd(CALIB_MEMORY_STATUS_OFFSET);
    wr(CALIB_MEMORY_STATUS_OFFSET, 32'h0);
    rd(CALIB_MEMORY_STATUS_OFFSET);
    rst(1'b1);
    rd(CALIB_MEMORY_STATUS_OFFSET);
    wr(OUTPUT_ONE_DATA_OFFSET, $random(seed));
    wr(OUTPUT_TWO_DATA_OFFSET, $random(seed));
    chk_w({20'h0, out_one}, mdl[4]);
    f0 = fires;
    for (i = 0; i < 3; i++) begin
      repeat (150) @(posedge pclk);
      svcl = ~svcl;
      wr_en(1'b1, 1'b1);
    end
    chk_w(32'(fires - f0), 32'h0);
    f0 = fires;
    n = 0;
    while (fires < f0 + 2 && n < 600) begin @(posedge pclk); n++; end
    if (n == 600) give_up();
    repeat (2) @(posedge pclk);
    chk_w({8'h0, out_one, out_two}, 32'h0);
    mdl[4] = 32'h0; mdl[5] = 32'h0; mdl[6] = 32'h1;
    rd(OUTPUT_TWO_DATA_OFFSET);
    rd(ENABLE_CONTROL_OFFSET);
    rd(RESET_CAUSE_OFFSET);
    wr(RESET_CAUSE_OFFSET, 32'h0);
    wr_en(1'b1, 1'b0);
    rd(RESET_CAUSE_OFFSET);
    f0 = fires;
    repeat (500) @(posedge pclk);
    chk_w(32'(fires - f0), 32'h0);
    wr(RAM_SELFTEST_STATUS_OFFSET, $random(seed));
    wr(8'h20, $random(seed));
    rd(8'h20);
    rd(RAM_SELFTEST_STATUS_OFFSET);
    crc_run(1'b0);
    rd(CALIB_MEMORY_STATUS_OFFSET);
    crc_run(1'b1);
    rd(CALIB_MEMORY_STATUS_OFFSET);
    wr(CALIB_MEMORY_STATUS_OFFSET, 32'h0);
    rd(CALIB_MEMORY_STATUS_OFFSET);
    wr(ENABLE_CONTROL_TWO_OFFSET, 32'h1);
    n = 0;
    q = 32'h0;
    while (q[SELFTEST_DONE_BIT] !== 1'b1 && n < 100) begin
      apb(1'b0, RAM_SELFTEST_STATUS_OFFSET, 32'h0, q);
      n++;
    end
    if (n == 100) give_up();
    mdl[3] = 32'h1;
    rd(RAM_SELFTEST_STATUS_OFFSET);
    wr(ENABLE_CONTROL_TWO_OFFSET, 32'h1);
    rd(RAM_SELFTEST_STATUS_OFFSET);
    rd(ENABLE_CONTROL_TWO_OFFSET);
    for (i = 0; i < 5; i++) begin
      if (i == 4) wr_en(1'b0, 1'b0);
      osc_mode <= (i == 4) ? 2'h3 : 2'(i);
      cnt = 0;
      repeat (2500) begin
        @(posedge pclk);
        if (device_reset_req === 1'b1) cnt++;
      end
      chk_b(cnt != 0, i == 2 || i == 3);
    end
    report_and_stop();
  end
endmodule // tb

//--- verilog/diagnostic_safety_monitor.sv
// file: diagnostic and safety monitor top with apb register slave
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/10ps
module diagnostic_safety_monitor
  import diag_pkg::*;
#(
  parameter int WD_CYCLES   = WD_TIMEOUT_CYCLES,
  parameter int RAM_DEPTH   = 256,
  parameter int RAM_AW      = 8
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 main_osc_clk,
  input  wire logic                 trim_valid,
  input  wire cal_byte_type         cal_byte,
  output logic                      core_reset_n,
  output logic                      device_reset_req,
  output logic      [DAC_WIDTH-1:0] analog_output_one,
  output logic      [DAC_WIDTH-1:0] analog_output_two
);

  // ****************************************************************
  // apb decode
  // ****************************************************************
  logic wr_en;
  logic rd_en;
  logic hit;
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;

  always_comb begin
    if (paddr == ENABLE_CONTROL_OFFSET) hit = 1'b1;
    else if (paddr == ENABLE_CONTROL_TWO_OFFSET) hit = 1'b1;
    else if (paddr == CALIB_MEMORY_STATUS_OFFSET) hit = 1'b1;
    else if (paddr == RAM_SELFTEST_STATUS_OFFSET) hit = 1'b1;
    else if (paddr == OUTPUT_ONE_DATA_OFFSET) hit = 1'b1;
    else if (paddr == OUTPUT_TWO_DATA_OFFSET) hit = 1'b1;
    else if (paddr == RESET_CAUSE_OFFSET) hit = 1'b1;
    else hit = 1'b0;
  end

  // ****************************************************************
  // control and data registers
  // ****************************************************************
  logic                 osc_en_r, osc_en_nxt;
  logic                 wd_en_r, wd_en_nxt;
  logic                 svc_r, svc_nxt;
  logic [DAC_WIDTH-1:0] out1_r, out1_nxt, out2_r, out2_nxt;
  logic                 wd_fire;
  logic                 start_wr;

  assign start_wr = wr_en && paddr == ENABLE_CONTROL_TWO_OFFSET
                    && pwdata[SELFTEST_START_BIT];

  always_comb begin
    osc_en_nxt = osc_en_r;
    wd_en_nxt  = wd_en_r;
    svc_nxt    = svc_r;
    out1_nxt   = out1_r;
    out2_nxt   = out2_r;
    if (wr_en && paddr == ENABLE_CONTROL_OFFSET) begin
      osc_en_nxt = pwdata[OSC_MON_EN_BIT];
      wd_en_nxt  = pwdata[CORE_WD_EN_BIT];
      svc_nxt    = pwdata[WD_SERVICE_BIT];
    end
    if (wr_en && paddr == OUTPUT_ONE_DATA_OFFSET) begin
      out1_nxt = pwdata[DAC_WIDTH-1:0];
    end
    if (wr_en && paddr == OUTPUT_TWO_DATA_OFFSET) begin
      out2_nxt = pwdata[DAC_WIDTH-1:0];
    end
    // only output data cleared; enables and others kept
    if (wd_fire) begin
      out1_nxt = '0;
      out2_nxt = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_en_r <= ENABLE_CONTROL_RESET[OSC_MON_EN_BIT];
      wd_en_r  <= ENABLE_CONTROL_RESET[CORE_WD_EN_BIT];
      svc_r    <= 1'b0;
      out1_r   <= '0;
      out2_r   <= '0;
    end else begin
      osc_en_r <= osc_en_nxt;
      wd_en_r  <= wd_en_nxt;
      svc_r    <= svc_nxt;
      out1_r   <= out1_nxt;
      out2_r   <= out2_nxt;
    end
  end

  assign analog_output_one = out1_r;
  assign analog_output_two = out2_r;

  // ****************************************************************
  // software watchdog
  // ****************************************************************
  logic        svc_d_r;
  logic [31:0] wd_cnt_r, wd_cnt_nxt;
  logic        cause_r, cause_nxt;
  logic        svc_toggle;

  assign svc_toggle = svc_r ^ svc_d_r;
  assign wd_fire    = wd_en_r && !svc_toggle
                      && wd_cnt_r == 32'(WD_CYCLES - 1);

  always_comb begin
    wd_cnt_nxt = wd_cnt_r + 32'h1;
    cause_nxt  = cause_r;
    if (!wd_en_r || svc_toggle || wd_fire) begin
      wd_cnt_nxt = '0;
    end
    if (wd_fire) begin
      cause_nxt = 1'b1;
    end else if (wr_en && paddr == RESET_CAUSE_OFFSET
                 && !pwdata[CAUSE_WD_BIT]) begin
      cause_nxt = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      svc_d_r  <= 1'b0;
      wd_cnt_r <= '0;
      cause_r  <= 1'b0;
    end else begin
      svc_d_r  <= svc_r;
      wd_cnt_r <= wd_cnt_nxt;
      cause_r  <= cause_nxt;
    end
  end

  // ****************************************************************
  // trim check and core reset
  // ****************************************************************
  logic trim_s1_r, trim_s2_r;
  logic trim_done_r, trim_done_nxt;
  logic trim_err_r, trim_err_nxt;
  logic core_rst_r, core_rst_nxt;

  always_comb begin
    trim_done_nxt = 1'b1;
    trim_err_nxt  = trim_err_r;
    if (!trim_done_r) begin
      trim_err_nxt = !trim_s2_r;
    end else if (wr_en && paddr == CALIB_MEMORY_STATUS_OFFSET
                 && !pwdata[TRIM_ERR_BIT]) begin
      trim_err_nxt = 1'b0;
    end
    // core held until the trim verdict is latched
    core_rst_nxt = trim_done_r && !wd_fire;
  end

  // synchroniser kept out of reset: it settles while reset is held
  always_ff @(posedge pclk) begin
    trim_s1_r <= trim_valid;
    trim_s2_r <= trim_s1_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_done_r <= 1'b0;
      trim_err_r  <= 1'b0;
      core_rst_r  <= 1'b0;
    end else begin
      trim_done_r <= trim_done_nxt;
      trim_err_r  <= trim_err_nxt;
      core_rst_r  <= core_rst_nxt;
    end
  end

  assign core_reset_n = core_rst_r;

  // ****************************************************************
  // calibration crc over every bank except bank zero
  // ****************************************************************
  logic [7:0] crc_r, crc_nxt;
  logic       crc_err_r, crc_err_nxt;
  logic [7:0] crc_step;
  logic       is_crc_byte;

  // serial crc-8 on one byte per load
  always_comb begin
    // bank one byte zero starts a fresh sum
    crc_step = ((cal_byte.bank == 3'h1 && cal_byte.index == 4'h0)
                ? CRC_INIT : crc_r) ^ cal_byte.data;
    for (int i = 0; i < 8; i++) begin
      crc_step = crc_step[7] ? ((crc_step << 1) ^ CRC_POLY)
                             : (crc_step << 1);
    end
  end

  assign is_crc_byte = cal_byte.bank == 3'(CRC_BANK)
                       && cal_byte.index == 4'(CRC_BYTE_INDEX);

  always_comb begin
    crc_nxt     = crc_r;
    crc_err_nxt = crc_err_r;
    if (cal_byte.load) begin
      if (is_crc_byte) begin
        crc_err_nxt = crc_r != cal_byte.data;
        crc_nxt     = CRC_INIT;
      end else if (cal_byte.bank != 3'h0) begin
        crc_nxt = crc_step; // bank zero excluded
      end
    end
    // hardware verdict wins over a same-cycle clear
    if (!(cal_byte.load && is_crc_byte) && wr_en
        && paddr == CALIB_MEMORY_STATUS_OFFSET
        && !pwdata[CRC_ERR_BIT]) begin
      crc_err_nxt = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_r     <= CRC_INIT;
      crc_err_r <= 1'b0;
    end else begin
      crc_r     <= crc_nxt;
      crc_err_r <= crc_err_nxt;
    end
  end

  // ****************************************************************
  // ram self-test, march write then read-verify
  // ****************************************************************
  bist_state_type    bist_r, bist_nxt;
  logic [RAM_AW-1:0] baddr_r, baddr_nxt;
  logic              bfail_r, bfail_nxt;
  logic              bused_r, bused_nxt;
  logic              rd_pend_r, rd_pend_nxt;
  logic [RAM_AW-1:0] chk_addr_r;
  logic [7:0]        ram_rdata;
  logic              ram_we;
  logic              bdone;

  assign ram_we = bist_r == BIST_WRITE;
  // done waits for the last word's verdict
  assign bdone  = bist_r == BIST_DONE && !rd_pend_r;

  always_comb begin
    bist_nxt    = bist_r;
    baddr_nxt   = baddr_r;
    bfail_nxt   = bfail_r;
    bused_nxt   = bused_r;
    rd_pend_nxt = 1'b0;
    case (bist_r)
      BIST_IDLE: begin
        if (start_wr && !bused_r) begin
          bist_nxt  = BIST_WRITE;
          bused_nxt = 1'b1;
          baddr_nxt = '0;
        end
      end
      BIST_WRITE: begin
        baddr_nxt = baddr_r + 1'b1;
        if (baddr_r == RAM_AW'(RAM_DEPTH - 1)) begin
          bist_nxt  = BIST_READ;
          baddr_nxt = '0;
        end
      end
      BIST_READ: begin
        rd_pend_nxt = 1'b1;
        baddr_nxt   = baddr_r + 1'b1;
        if (baddr_r == RAM_AW'(RAM_DEPTH - 1)) begin
          bist_nxt = BIST_DONE;
        end
      end
      default: begin
        bist_nxt = BIST_DONE;
      end
    endcase
    // pattern is address xor 0x55
    if (rd_pend_r && ram_rdata != (8'(chk_addr_r) ^ 8'h55)) begin
      bfail_nxt = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bist_r     <= BIST_IDLE;
      baddr_r    <= '0;
      bfail_r    <= 1'b0;
      bused_r    <= 1'b0;
      rd_pend_r  <= 1'b0;
      chk_addr_r <= '0;
    end else begin
      bist_r     <= bist_nxt;
      baddr_r    <= baddr_nxt;
      bfail_r    <= bfail_nxt;
      bused_r    <= bused_nxt;
      rd_pend_r  <= rd_pend_nxt;
      chk_addr_r <= baddr_r;
    end
  end

  selftest_ram #(.DEPTH(RAM_DEPTH), .AW(RAM_AW)) u_ram (
    .pclk  (pclk),
    .we    (ram_we),
    .addr  (baddr_r),
    .wdata (8'(baddr_r) ^ 8'h55),
    .rdata (ram_rdata)
  );

  // ****************************************************************
  // main oscillator frequency monitor
  // ****************************************************************
  logic        osc_s1_r, osc_s2_r, osc_s3_r;
  logic [15:0] gate_r, gate_nxt, edges_r, edges_nxt;
  logic        dev_rst_r, dev_rst_nxt;

  // sampled at 100 MHz: only sees up to 50 MHz, enough for the window
  always_comb begin
    gate_nxt    = gate_r + 16'h1;
    edges_nxt   = edges_r + {15'h0, osc_s2_r & ~osc_s3_r};
    dev_rst_nxt = 1'b0;
    if (!osc_en_r) begin
      gate_nxt  = '0;
      edges_nxt = '0;
    end else if (gate_r == 16'(OSC_GATE_CYCLES - 1)) begin
      gate_nxt    = '0;
      edges_nxt   = '0;
      dev_rst_nxt = edges_r < 16'(OSC_MIN_COUNT)
                    || edges_r > 16'(OSC_MAX_COUNT);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_s1_r  <= 1'b0;
      osc_s2_r  <= 1'b0;
      osc_s3_r  <= 1'b0;
      gate_r    <= '0;
      edges_r   <= '0;
      dev_rst_r <= 1'b0;
    end else begin
      osc_s1_r  <= main_osc_clk;
      osc_s2_r  <= osc_s1_r;
      osc_s3_r  <= osc_s2_r;
      gate_r    <= gate_nxt;
      edges_r   <= edges_nxt;
      dev_rst_r <= dev_rst_nxt;
    end
  end

  assign device_reset_req = dev_rst_r;

  // ****************************************************************
  // read mux, service level deliberately not readable
  // ****************************************************************
  always_comb begin
    prdata = '0;
    if (!rd_en) prdata = '0;
    else if (paddr == ENABLE_CONTROL_OFFSET)
      prdata = {30'h0, wd_en_r, osc_en_r};
    else if (paddr == CALIB_MEMORY_STATUS_OFFSET)
      prdata = {30'h0, trim_err_r, crc_err_r};
    else if (paddr == RAM_SELFTEST_STATUS_OFFSET)
      prdata = {30'h0, bfail_r && bdone, bdone};
    else if (paddr == OUTPUT_ONE_DATA_OFFSET)
      prdata = {20'h0, out1_r};
    else if (paddr == OUTPUT_TWO_DATA_OFFSET)
      prdata = {20'h0, out2_r};
    else if (paddr == RESET_CAUSE_OFFSET)
      prdata = {31'h0, cause_r};
    else prdata = '0;
  end

endmodule // diagnostic_safety_monitor

//--- verilog/selftest_ram.sv
// file: small synchronous ram with registered read data under test
`timescale 1ns/10ps
module selftest_ram
  import diag_pkg::*;
#(
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic          pclk,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  output logic      [7:0]    rdata
);

  logic [7:0] mem [DEPTH];

  // no reset on the array: contents are whatever power-up left
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule // selftest_ram
